/* rtl/dcsi_pkg.sv */
package dcsi_pkg;
	// register byte offsets
	localparam logic [7:0] ctrl_off   = 8'h10; // channel_control
	localparam logic [7:0] flags_off  = 8'h14; // channel_irq_flags
	localparam logic [7:0] enable_off = 8'h18; // channel_irq_enables
	localparam logic [7:0] addr_off   = 8'h1c; // memory current address (own)
	localparam logic [7:0] end_off    = 8'h20; // memory end address (own)
	// control field positions
	localparam int run_bit     = 0;
	localparam int req_bit     = 1;
	localparam int done_bit    = 2;
	localparam int busy_bit    = 5;
	localparam int dir_bit     = 8;
	localparam int sel_lo      = 9;
	localparam int sel_hi      = 15;
	localparam int dis_hw_bit  = 19;
	localparam int size_lo     = 20;
	localparam int size_hi     = 22;
	localparam int go_bit      = 24;
	localparam int abort_bit   = 25;
	// irq flag positions
	localparam int flag_bus    = 0;
	localparam int flag_flow   = 1;
	localparam int flag_done   = 2;
	// reset values
	localparam logic [31:0] ctrl_rst  = 32'h0000_0000;
	localparam logic [2:0]  flags_rst = 3'h0;
	// bus responses
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	// number of flow-control masters on the concatenated bus
	localparam int fc_width = 128;
	// channel states
	typedef enum logic [1:0] {
		dcsi_idle  = 2'b00,
		dcsi_read  = 2'b01,
		dcsi_write = 2'b10
	} dcsi_state_t;
	// one memory-side bus beat
	typedef struct packed {
		logic        valid; // beat request
		logic        write; // 1 write, 0 read
		logic [31:0] addr;  // byte address
		logic [2:0]  size;  // bytes per packet
	} dcsi_beat_t;
endpackage

/* rtl/dcsi_channel.sv */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
// Operation
// - seven-bit field selects flow-control master index
// - direction 1 memory to device, 0 reverse
// - busy reads 1 when not idle
// - done equals not busy and run
// - request shows selected master request
// - requests serviced only while run set
// - completion flag when address reaches end
// - terminate from master sets completion but never the completion flag
// - request after completion sets flow error
// - bus error response sets bus error flag
// - enable gates completion flag to interrupt
// - enable gates flow error flag to interrupt
// - enable gates bus error flag to interrupt
// - packet sizes one, two, four bytes only
// - abort forces channel back to idle
module dcsi_channel (
	input  wire logic                          core_clk,      // system clock
	input  wire logic                          rst,           // sync reset, active high
	input  wire logic [31:0]                   s_axi_awaddr,  // write address
	input  wire logic                          s_axi_awvalid, // write address valid
	output logic                               s_axi_awready, // write address ready
	input  wire logic [31:0]                   s_axi_wdata,   // write data
	input  wire logic [3:0]                    s_axi_wstrb,   // byte strobes
	input  wire logic                          s_axi_wvalid,  // write data valid
	output logic                               s_axi_wready,  // write data ready
	output logic [1:0]                         s_axi_bresp,   // write response
	output logic                               s_axi_bvalid,  // write response valid
	input  wire logic                          s_axi_bready,  // write response ready
	input  wire logic [31:0]                   s_axi_araddr,  // read address
	input  wire logic                          s_axi_arvalid, // read address valid
	output logic                               s_axi_arready, // read address ready
	output logic [31:0]                        s_axi_rdata,   // read data
	output logic [1:0]                         s_axi_rresp,   // read response
	output logic                               s_axi_rvalid,  // read data valid
	input  wire logic                          s_axi_rready,  // read data ready
	input  wire logic [dcsi_pkg::fc_width-1:0] fc_req,        // concatenated requests, async
	input  wire logic [dcsi_pkg::fc_width-1:0] fc_term,       // concatenated terminates, async
	output dcsi_pkg::dcsi_beat_t               mem_beat,      // data-path beat request
	input  wire logic                          mem_ack,       // beat finished, same clock
	input  wire logic                          mem_err,       // error response with ack
	output logic                               fc_ack,        // packet done to master
	output logic                               irq            // channel interrupt level
);
	// write and read channel holding state
	logic        aw_held, next_aw_held;   // address taken
	logic        w_held, next_w_held;     // data taken
	logic [7:0]  aw_addr, next_aw_addr;   // latched offset
	logic [31:0] w_data, next_w_data;     // latched data
	logic [3:0]  w_strb, next_w_strb;     // latched strobes
	logic        bvalid, next_bvalid;     // response pending
	logic [1:0]  bresp, next_bresp;       // response code
	logic        rvalid, next_rvalid;     // read pending
	logic [31:0] rdata, next_rdata;       // read data
	logic [1:0]  rresp, next_rresp;       // read code
	// register state
	logic [31:0] ctrl, next_ctrl;         // control word (writable bits)
	logic [2:0]  flags, next_flags;       // sticky irq flags
	logic [2:0]  enables, next_enables;   // irq enables
	logic [31:0] cur_addr, next_cur_addr; // memory current address
	logic [31:0] end_addr, next_end_addr; // memory end address
	logic        complete, next_complete; // transfer reached end
	dcsi_pkg::dcsi_state_t state, next_state; // channel machine
	dcsi_pkg::dcsi_beat_t  beat, next_beat;   // registered beat request
	logic        ack_q, next_ack_q;       // registered packet ack
	logic        irq_q, next_irq_q;       // registered interrupt
	// three-stage synchronisers for selected request and terminate
	logic [2:0]  req_sync;                // request stages
	logic [2:0]  term_sync;               // terminate stages
	logic        req_lvl, next_req_lvl;   // filtered request
	logic        term_lvl, next_term_lvl; // filtered terminate
	logic [6:0]  sel;                     // selected master index

	// byte-lane merge for a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// packet size legal: 1, 2 or 4 bytes
	function automatic logic size_ok(input logic [2:0] sz);
		return (sz == 3'h1) || (sz == 3'h2) || (sz == 3'h4);
	endfunction

	assign sel = ctrl[dcsi_pkg::sel_hi:dcsi_pkg::sel_lo];

	// synchroniser chain; first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_sync  <= 3'h0;
			term_sync <= 3'h0;
		end else begin
			req_sync  <= {req_sync[1:0], fc_req[sel]};
			term_sync <= {term_sync[1:0], fc_term[sel]};
		end
	end

	// level changes once stages two and three agree
	always_comb begin
		next_req_lvl  = req_lvl;
		next_term_lvl = term_lvl;
		if (req_sync[1] == req_sync[2]) begin
			next_req_lvl = req_sync[2];
		end
		if (term_sync[1] == term_sync[2]) begin
			next_term_lvl = term_sync[2];
		end
	end

	// bus slave and register next values
	always_comb begin
		logic        wr_go;  // both write halves present
		logic        hw_ok;  // hardware flow control serviceable
		logic [2:0]  set;    // flag set events
		logic [2:0]  clr;    // flag clears by software
		logic [31:0] pkt;    // packet size as address step
		logic [31:0] status; // read view of control
		wr_go = 1'b0;
		set = 3'h0;
		clr = 3'h0;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_ctrl = ctrl;
		next_flags = flags;
		next_enables = enables;
		next_cur_addr = cur_addr;
		next_end_addr = end_addr;
		next_complete = complete;
		next_state = state;
		next_beat = beat;
		next_ack_q = 1'b0;
		pkt = {29'h0, ctrl[dcsi_pkg::size_hi:dcsi_pkg::size_lo]};
		hw_ok = ctrl[dcsi_pkg::run_bit] && !ctrl[dcsi_pkg::dis_hw_bit];
		// read view: live busy, done and request bits
		status = ctrl;
		status[dcsi_pkg::busy_bit] = (state != dcsi_pkg::dcsi_idle);
		status[dcsi_pkg::done_bit] = !status[dcsi_pkg::busy_bit] && ctrl[dcsi_pkg::run_bit];
		status[dcsi_pkg::req_bit] = req_lvl;
		// address and data accepted in either order
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_held && w_held && !bvalid) begin
			wr_go = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = dcsi_pkg::resp_okay;
			case (aw_addr)
				// control: reserved bit 23 and status bits stay zero
				dcsi_pkg::ctrl_off: next_ctrl = merge(ctrl, w_data, w_strb) & 32'h037f_ff01;
				dcsi_pkg::flags_off: begin
					if (w_strb[0]) begin
						clr = w_data[2:0];
					end
				end
				dcsi_pkg::enable_off: begin
					if (w_strb[0]) begin
						next_enables = w_data[2:0];
					end
				end
				dcsi_pkg::addr_off: next_cur_addr = merge(cur_addr, w_data, w_strb);
				dcsi_pkg::end_off: next_end_addr = merge(end_addr, w_data, w_strb);
				default: next_bresp = dcsi_pkg::resp_slverr; // unmapped
			endcase
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = dcsi_pkg::resp_okay;
			case (s_axi_araddr[7:0])
				dcsi_pkg::ctrl_off: next_rdata = status;
				dcsi_pkg::flags_off: next_rdata = {29'h0, flags};
				dcsi_pkg::enable_off: next_rdata = {29'h0, enables};
				dcsi_pkg::addr_off: next_rdata = cur_addr;
				dcsi_pkg::end_off: next_rdata = end_addr;
				default: begin
					next_rdata = 32'h0;
					next_rresp = dcsi_pkg::resp_slverr;
				end
			endcase
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		// channel machine
		if (ctrl[dcsi_pkg::abort_bit]) begin
			next_state = dcsi_pkg::dcsi_idle;
			next_beat.valid = 1'b0;
			next_ctrl[dcsi_pkg::abort_bit] = 1'b0;
			next_ctrl[dcsi_pkg::go_bit] = 1'b0;
		end else begin
			case (state)
				dcsi_pkg::dcsi_idle: begin
					if (complete && hw_ok && req_lvl) begin
						set[dcsi_pkg::flag_flow] = 1'b1;
					end
					if (!complete && size_ok(pkt[2:0]) && (hw_ok && req_lvl
						|| ctrl[dcsi_pkg::dis_hw_bit] && ctrl[dcsi_pkg::go_bit])) begin
						next_state = dcsi_pkg::dcsi_read;
						next_beat.valid = 1'b1;
						next_beat.write = 1'b0;
						next_beat.size = pkt[2:0];
						// direction picks the read side
						next_beat.addr = ctrl[dcsi_pkg::dir_bit] ? cur_addr : 32'h0;
					end
				end
				dcsi_pkg::dcsi_read: begin
					if (mem_ack) begin
						next_state = dcsi_pkg::dcsi_write;
						next_beat.write = 1'b1;
						next_beat.addr = ctrl[dcsi_pkg::dir_bit] ? 32'h0 : cur_addr;
						if (mem_err) begin
							set[dcsi_pkg::flag_bus] = 1'b1;
							next_state = dcsi_pkg::dcsi_idle;
							next_beat.valid = 1'b0;
						end
					end
				end
				dcsi_pkg::dcsi_write: begin
					if (mem_ack) begin
						next_state = dcsi_pkg::dcsi_idle;
						next_beat.valid = 1'b0;
						next_ack_q = 1'b1;
						next_cur_addr = cur_addr + pkt;
						if (mem_err) begin
							set[dcsi_pkg::flag_bus] = 1'b1;
						end else if (term_lvl) begin
							next_complete = 1'b1;
						end else if (cur_addr + pkt == end_addr) begin
							next_complete = 1'b1;
							set[dcsi_pkg::flag_done] = 1'b1;
						end
					end
				end
				default: next_state = dcsi_pkg::dcsi_idle;
			endcase
		end
		// rerun clears completion when software moves the address
		if (wr_go && aw_addr == dcsi_pkg::addr_off) begin
			next_complete = 1'b0;
		end
		// set wins over clear
		next_flags = (flags & ~clr) | set;
		next_irq_q = |(next_flags & enables);
	end

	// register everything
	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h0;
			w_strb   <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= dcsi_pkg::resp_okay;
			rvalid   <= 1'b0;
			rdata    <= 32'h0;
			rresp    <= dcsi_pkg::resp_okay;
			ctrl     <= dcsi_pkg::ctrl_rst;
			flags    <= dcsi_pkg::flags_rst;
			enables  <= 3'h0;
			cur_addr <= 32'h0;
			end_addr <= 32'h0;
			complete <= 1'b0;
			state    <= dcsi_pkg::dcsi_idle;
			beat     <= '0;
			ack_q    <= 1'b0;
			irq_q    <= 1'b0;
			req_lvl  <= 1'b0;
			term_lvl <= 1'b0;
		end else begin
			aw_held  <= next_aw_held;
			w_held   <= next_w_held;
			aw_addr  <= next_aw_addr;
			w_data   <= next_w_data;
			w_strb   <= next_w_strb;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			rvalid   <= next_rvalid;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
			ctrl     <= next_ctrl;
			flags    <= next_flags;
			enables  <= next_enables;
			cur_addr <= next_cur_addr;
			end_addr <= next_end_addr;
			complete <= next_complete;
			state    <= next_state;
			beat     <= next_beat;
			ack_q    <= next_ack_q;
			irq_q    <= next_irq_q;
			req_lvl  <= next_req_lvl;
			term_lvl <= next_term_lvl;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;
	assign mem_beat      = beat;
	assign fc_ack        = ack_q;
	assign irq           = irq_q;
endmodule // dcsi_channel

/* dv/dcsi_asserts.sv */
`timescale 1ns/10ps
// port-level checks on the channel
module dcsi_asserts (
	input wire logic                 core_clk,      // clock
	input wire logic                 rst,           // sync reset
	input wire logic                 s_axi_awready, // write address ready
	input wire logic                 s_axi_wready,  // write data ready
	input wire logic                 s_axi_arready, // read address ready
	input wire logic                 s_axi_bvalid,  // write response valid
	input wire logic                 s_axi_rvalid,  // read data valid
	input wire dcsi_pkg::dcsi_beat_t mem_beat,      // beat request
	input wire logic                 mem_ack,       // beat finished
	input wire logic                 mem_err,       // error response
	input wire logic                 fc_ack         // packet done
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// read beat finished cleanly, or with an error
	sequence s_rd_ok;
		mem_beat.valid && !mem_beat.write && mem_ack && !mem_err;
	endsequence
	sequence s_rd_err;
		mem_beat.valid && !mem_beat.write && mem_ack && mem_err;
	endsequence
	a_resp_after: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
		else $error("write response without both halves held");
	a_r_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during response");
	a_ack_pulse: assert property (fc_ack |=> !fc_ack)
		else $error("packet done longer than one cycle");
	a_ack_cause: assert property (fc_ack |-> $past(mem_ack))
		else $error("packet done without a finished beat");
	a_read_first: assert property ($rose(mem_beat.valid) |-> !mem_beat.write)
		else $error("packet began with a write");
	a_write_next: assert property (s_rd_ok |-> ##[1:2] (mem_beat.valid && mem_beat.write))
		else $error("no write after read");
	a_err_skip: assert property (s_rd_err |=> !mem_beat.valid)
		else $error("write after failed read");
	a_size_legal: assert property (mem_beat.valid |-> mem_beat.size inside {3'h1, 3'h2, 3'h4})
		else $error("illegal packet size");
endmodule // dcsi_asserts

/* dv/dcsi_fc_model.sv */
`timescale 1ns/10ps
// flow-control master plus memory-side responder
module dcsi_fc_model (
	input wire logic                 core_clk, // clock
	input wire logic                 rst,      // sync reset
	input wire logic [6:0]           idx,      // our bus index
	input wire logic                 ld,       // load packet count
	input wire logic [7:0]           ld_n,     // packets wanted
	input wire logic                 ovf,      // keep requesting regardless
	input wire logic                 term,     // terminate level
	input wire logic                 err,      // answer beats with error
	input wire logic [7:0]           lat,      // beat wait cycles
	input wire logic                 fc_ack,   // packet done
	input wire dcsi_pkg::dcsi_beat_t mem_beat, // beat request
	output logic [127:0]             fc_req,   // concatenated requests
	output logic [127:0]             fc_term,  // concatenated terminates
	output logic                     mem_ack,  // beat finished
	output logic                     mem_err   // error with ack
);
	logic [7:0] left; // packets still wanted
	logic [7:0] cnt;  // cycles spent on a beat
	logic       r;    // request level at our index
	logic       hit;  // beat finishes now
	// drop the level once the last packet is under way: the channel sees it
	// several cycles late, and a stale level after completion is an overflow
	assign r = ovf || (left > 8'h01) || (left == 8'h01 && !mem_beat.valid && !fc_ack);
	// other masters show the opposite level, so a wrong index is seen
	assign fc_req = r ? (128'h1 << idx) : ~(128'h1 << idx);
	assign fc_term = term ? (128'h1 << idx) : ~(128'h1 << idx);
	assign hit = mem_beat.valid && !mem_ack && (cnt >= lat);
	// packet count and beat answers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			left <= 8'h00;
			cnt <= 8'h00;
			mem_ack <= 1'b0;
		end else begin
			if (ld) left <= ld_n;
			else if (fc_ack && left != 8'h00) left <= left - 8'h01;
			mem_ack <= hit;
			cnt <= (hit || !mem_beat.valid) ? 8'h00 : cnt + 8'h01;
		end
		mem_err <= hit ? err : ~mem_err; // meaningless between answers
	end
endmodule // dcsi_fc_model

/* dv/dma_channel_status_irq_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module dma_channel_status_irq_tb;
	logic core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_a, wr_a, v;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0] s_axi_wstrb;
	logic [127:0] fc_req, fc_term;
	dcsi_pkg::dcsi_beat_t mem_beat;
	logic mem_ack, mem_err, fc_ack, irq, ld, ovf, term, err;
	logic [7:0] ld_n, lat;
	int n_mismatch, n_tests, n_ack, k;
	dcsi_channel dut_u (.*);
	dcsi_fc_model fcm_u (.core_clk, .rst, .idx(7'h05), .ld, .ld_n, .ovf, .term, .err, .lat,
		.fc_ack, .mem_beat, .fc_req, .fc_term, .mem_ack, .mem_err);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// count packets and note beat addresses
	always @(posedge core_clk) begin
		if (fc_ack === 1'b1) n_ack++;
		if (mem_ack && mem_beat.valid && mem_beat.write) wr_a <= mem_beat.addr;
		if (mem_ack && mem_beat.valid && !mem_beat.write) rd_a <= mem_beat.addr;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic hang(input int n);
		if (n >= 300) begin
			n_mismatch++;
			give_verdict;
		end
	endtask
	// write one word; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 300);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		hang(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 300);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		hang(n);
	endtask
	task automatic load(input logic [7:0] n);
		@(posedge core_clk);
		ld <= 1'b1;
		ld_n <= n;
		@(posedge core_clk);
		ld <= 1'b0;
	endtask
	task automatic wack(input int t);
		int n;
		n = 0;
		while (n_ack < t && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		hang(n);
		tick(3);
	endtask
	// control word with master index 5
	function automatic logic [31:0] ctl(input logic [2:0] sz, input logic run, dir, ab);
		return {6'h00, ab, 2'h0, sz, 4'h0, 7'h05, dir, 7'h00, run};
	endfunction
	task automatic give_verdict;
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{ld, ovf, term, err, ld_n, lat} = 20'h0;
		{n_mismatch, n_tests, n_ack} = 96'h0;
		s_axi_wstrb = 4'hf;
		rst = 1'b1;
		tick(3);
		rst <= 1'b0;
		// let the request synchroniser settle before the first read
		tick(4);
		// index 0 idles high in the model, so request reads set
		rd(dcsi_pkg::ctrl_off); `CHK("ctrl reset", 32'h2, v)
		rd(dcsi_pkg::flags_off); `CHK("flags reset", 32'h0, v)
		rd(dcsi_pkg::enable_off); `CHK("enables reset", 32'h0, v)
		rd(8'h40); `CHK("unmapped resp", dcsi_pkg::resp_slverr, rsp)
		wr(8'h44, 32'h0); `CHK("unmapped wr resp", dcsi_pkg::resp_slverr, rsp)
		// run off: request visible yet ignored
		wr(dcsi_pkg::end_off, 32'h108);
		wr(dcsi_pkg::addr_off, 32'h100);
		wr(dcsi_pkg::enable_off, 32'h4);
		load(8'h02);
		wr(dcsi_pkg::ctrl_off, ctl(3'h4, 1'b0, 1'b1, 1'b0));
		tick(10);
		rd(dcsi_pkg::ctrl_off); `CHK("req", 1'b1, v[1])
		`CHK("sel dir", 8'h0b, v[15:8])
		`CHK("busy off", 1'b0, v[5])
		`CHK("done off", 1'b0, v[2])
		`CHK("no packets", 0, n_ack)
		// two packets memory to device
		wr(dcsi_pkg::ctrl_off, ctl(3'h4, 1'b1, 1'b1, 1'b0));
		wack(2);
		`CHK("read addr", 32'h104, rd_a)
		`CHK("write addr", 32'h0, wr_a)
		rd(dcsi_pkg::flags_off); `CHK("done flag", 32'h4, v)
		`CHK("irq done", 1'b1, irq)
		rd(dcsi_pkg::ctrl_off); `CHK("status", 3'h2, {v[5], v[2], v[1]})
		// request after completion
		ovf <= 1'b1;
		tick(10);
		rd(dcsi_pkg::flags_off); `CHK("flow flag", 32'h6, v)
		wr(dcsi_pkg::flags_off, 32'h4);
		`CHK("irq masked", 1'b0, irq)
		wr(dcsi_pkg::enable_off, 32'h2);
		tick(2); `CHK("irq flow", 1'b1, irq)
		ovf <= 1'b0;
		// wait out the synchroniser so hardware no longer sets the flag
		tick(6);
		wr(dcsi_pkg::flags_off, 32'h0);
		rd(dcsi_pkg::flags_off); `CHK("w0 keeps", 32'h2, v)
		wr(dcsi_pkg::flags_off, 32'h2);
		rd(dcsi_pkg::flags_off); `CHK("w1 clears", 32'h0, v)
		`CHK("irq clear", 1'b0, irq)
		// terminated last packet, device to memory
		wr(dcsi_pkg::enable_off, 32'h7);
		wr(dcsi_pkg::ctrl_off, ctl(3'h4, 1'b1, 1'b0, 1'b0));
		wr(dcsi_pkg::end_off, 32'h204);
		wr(dcsi_pkg::addr_off, 32'h200);
		term <= 1'b1;
		load(8'h01);
		wack(3);
		`CHK("dev read", 32'h0, rd_a)
		`CHK("mem write", 32'h200, wr_a)
		rd(dcsi_pkg::flags_off); `CHK("term no flag", 32'h0, v)
		// bus error
		term <= 1'b0;
		err <= 1'b1;
		wr(dcsi_pkg::end_off, 32'h304);
		wr(dcsi_pkg::addr_off, 32'h300);
		load(8'h01);
		tick(20);
		load(8'h00);
		// let the last failing packet end before answers turn clean
		tick(10);
		err <= 1'b0;
		rd(dcsi_pkg::flags_off); `CHK("bus flag", 1'b1, v[0])
		`CHK("irq bus", 1'b1, irq)
		wr(dcsi_pkg::flags_off, 32'h7);
		// abort a stalled packet
		lat <= 8'd60;
		wr(dcsi_pkg::end_off, 32'h404);
		wr(dcsi_pkg::addr_off, 32'h400);
		load(8'h01);
		tick(8);
		rd(dcsi_pkg::ctrl_off); `CHK("busy", 2'h2, {v[5], v[2]})
		load(8'h00);
		wr(dcsi_pkg::ctrl_off, ctl(3'h4, 1'b1, 1'b0, 1'b1));
		rd(dcsi_pkg::ctrl_off); `CHK("aborted", 1'b0, v[5])
		// illegal size never starts
		lat <= 8'd0;
		k = n_ack;
		wr(dcsi_pkg::ctrl_off, ctl(3'h3, 1'b1, 1'b0, 1'b0));
		wr(dcsi_pkg::addr_off, 32'h500);
		load(8'h01);
		tick(20);
		`CHK("bad size", k, n_ack)
		rd(dcsi_pkg::ctrl_off); `CHK("bad size idle", 1'b0, v[5])
		give_verdict;
	end
endmodule // dma_channel_status_irq_tb
bind dcsi_channel dcsi_asserts chk_u (.core_clk, .rst, .s_axi_awready, .s_axi_arready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .mem_beat, .mem_ack, .mem_err, .fc_ack);
